// *** rtl/ir_input_conditioner.sv ***
`timescale 1ns/1ps
// synchroniser, glitch filter and edge detector for the demodulator input
module ir_input_conditioner
    import ir_timer_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic pin_i,
    input wire logic [1:0] filter_i,
    output logic rise_o,
    output logic fall_o
);
    logic sync1_q;
    logic sync2_q;
    logic level_q;
    logic [3:0] stable_q;
    logic [3:0] stable_d;
    logic [3:0] need;
    logic differs;
    logic accept;

    assign need = (filter_i == FILT_SHORT) ? 4'(FILT_SHORT_CLKS) :
                  (filter_i == FILT_LONG) ? 4'(FILT_LONG_CLKS) : 4'h0;
    assign differs = sync2_q != level_q;
    // a new level must hold for the whole filter width before it counts
    assign accept = differs && (stable_q + 4'h1 >= need);
    assign stable_d = (!differs || accept) ? 4'h0 : stable_q + 4'h1;

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            // reset to the idle-high level so no false edge follows reset
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            level_q <= 1'b1;
            stable_q <= 4'h0;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end
        else
        begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            stable_q <= stable_d;
            if (accept)
            begin
                level_q <= sync2_q;
            end
            rise_o <= accept && sync2_q;
            fall_o <= accept && !sync2_q;
        end
    end
endmodule // ir_input_conditioner

// *** rtl/ir_prescaler.sv ***
`timescale 1ns/1ps
// one-cycle tick at sysclk, /2, /4 or /8
module ir_prescaler
    import ir_timer_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic [1:0] sel_i,
    output logic tick_o
);
    logic [PRESCALE_W-1:0] div_q;
    logic [PRESCALE_W-1:0] div_d;
    logic [PRESCALE_W-1:0] mask;
    logic tick_d;

    // the divider restarts whenever the counter is stopped, so the first
    // tick after enabling comes one clock after the enable, at a fixed phase
    assign div_d = run_i ? div_q + 3'h1 : 3'h0;
    assign mask = (sel_i == 2'h0) ? 3'h0 :
                  (sel_i == 2'h1) ? 3'h1 :
                  (sel_i == 2'h2) ? 3'h3 : 3'h7;
    assign tick_d = run_i && ((div_q & mask) == 3'h0);

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            div_q <= 3'h0;
            tick_o <= 1'b0;
        end
        else
        begin
            div_q <= div_d;
            tick_o <= tick_d;
        end
    end
endmodule // ir_prescaler

// *** rtl/ir_timer_control_regs.sv ***
`timescale 1ns/1ps
// Summary of operation
// - narrow timeout flag sets at terminal count; only writing 1 clears it
// - first prescaled tick may be partial; clear timeout before enabling
// - demodulation, capture mask set: narrow capture raises interrupt request
// - narrow counter mask set: each narrow timeout raises interrupt request
// - shared bit 7 selects transmit (0) or demodulation (1); reset 0
// - transmit: shared bit 6 routes combined pin to port or logic output
// - demodulation: shared bit 6 picks first or second input pin
// - transmit: bits 5:4 combine outputs as AND, OR, NOR, NAND
// - demodulation: bits 5:4 select falling, rising or both edges
// - transmit: bits 3:2 normal, alternating, force wide output 0 or 1
// - demodulation: bits 3:2 filter pulses under 4 or 8 clocks
// - narrow start level from bit 1; opposite level while disabled
// - demodulation: bit 1 is rise flag, set by edge, cleared by 1
// - wide start level from bit 0 in normal or alternating; opposite idle
// - demodulation: bit 0 is fall flag, set by edge, cleared by 1
// - wide bit 7 reads running state; write 1 starts, 0 stops
// - transmit: wide bit 6 chooses reload or stop at terminal count
// - demodulation: wide bit 6 chooses every edge or first edge only
// - wide timeout flag sets at terminal count; writing 1 clears
// - wide bits 4:3 select clock divide by 1, 2, 4 or 8
// - wide bit 2 enables capture request, bit 1 timeout request
module ir_timer_control_regs
    import ir_timer_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // register port
    input wire logic [REG_ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // events from the counting datapaths
    input wire logic narrow_tc_i,
    input wire logic wide_tc_i,
    input wire logic narrow_capture_i,
    input wire logic wide_capture_i,
    input wire logic narrow_toggle_i,
    input wire logic wide_toggle_i,
    // controls to the counting datapaths
    output logic narrow_run_o,
    output logic wide_run_o,
    output logic narrow_tick_o,
    output logic wide_tick_o,
    output logic demod_mode_o,
    output logic narrow_single_o,
    output logic wide_single_o,
    output logic alternating_submode_o,
    output logic edge_rise_o,
    output logic edge_fall_o,
    output logic narrow_irq_o,
    output logic wide_irq_o,
    // port pins
    input wire logic first_input_pin_i,
    input wire logic second_input_pin_i,
    input wire logic [2:0] port_data_i,
    output logic narrow_out_pin_o,
    output logic wide_out_pin_o,
    output logic combined_out_pin_o,
    output logic narrow_counter_output_o,
    output logic wide_counter_output_o
);
    logic [7:0] narrow_ctrl_q;
    logic [7:0] shared_ctrl_q;
    logic [7:0] wide_ctrl_q;
    logic rise_flag_q;
    logic fall_flag_q;
    logic narrow_lvl_q;
    logic wide_lvl_q;
    logic combined_q;
    logic demod_in_q;
    logic [1:0] first_sync_q;
    logic [1:0] second_sync_q;

    logic wr_narrow;
    logic wr_shared;
    logic wr_wide;
    logic demod;
    logic narrow_en;
    logic wide_en;
    logic narrow_en_d;
    logic wide_en_d;
    logic narrow_start;
    logic wide_start;
    logic narrow_to_d;
    logic wide_to_d;
    logic rise_flag_d;
    logic fall_flag_d;
    logic narrow_lvl_d;
    logic wide_lvl_d;
    logic combined_d;
    logic [1:0] sub;
    logic [1:0] edge_sel;
    logic cond_rise;
    logic cond_fall;
    logic rise_hit;
    logic fall_hit;
    logic [7:0] shared_rd;
    logic [7:0] rdata_d;
    logic [7:0] narrow_ctrl_d;
    logic [7:0] shared_ctrl_d;
    logic [7:0] wide_ctrl_d;

    assign wr_narrow = reg_wr_i && (reg_addr_i == NARROW_CTRL_OFS);
    assign wr_shared = reg_wr_i && (reg_addr_i == SHARED_CTRL_OFS);
    assign wr_wide = reg_wr_i && (reg_addr_i == WIDE_CTRL_OFS);

    assign demod = shared_ctrl_q[SC_MODE];
    assign narrow_en = narrow_ctrl_q[NC_ENABLE];
    assign wide_en = wide_ctrl_q[WC_ENABLE];
    assign sub = shared_ctrl_q[SC_SUB_HI:SC_SUB_LO];
    assign edge_sel = shared_ctrl_q[SC_LOGIC_HI:SC_LOGIC_LO];

    // single pass in transmit stops the counter at terminal count
    assign narrow_en_d = wr_narrow ? reg_wdata_i[NC_ENABLE] :
        (narrow_en && !(narrow_tc_i && !demod && narrow_ctrl_q[NC_SINGLE]));
    assign wide_en_d = wr_wide ? reg_wdata_i[WC_ENABLE] :
        (wide_en && !(wide_tc_i && !demod && wide_ctrl_q[WC_SINGLE]));
    assign narrow_start = narrow_en_d && !narrow_en;
    assign wide_start = wide_en_d && !wide_en;

    // set wins over a clearing write in the same cycle
    assign narrow_to_d = narrow_tc_i || (narrow_ctrl_q[NC_TIMEOUT] &&
        !(wr_narrow && reg_wdata_i[NC_TIMEOUT]));
    assign wide_to_d = wide_tc_i || (wide_ctrl_q[WC_TIMEOUT] &&
        !(wr_wide && reg_wdata_i[WC_TIMEOUT]));

    assign narrow_ctrl_d = {narrow_en_d, reg_wdata_i[6], narrow_to_d,
        reg_wdata_i[4:0]};
    assign wide_ctrl_d = {wide_en_d, reg_wdata_i[6], wide_to_d,
        reg_wdata_i[4:0]};
    // bits 1:0 of the shared register keep the start levels only
    assign shared_ctrl_d = {reg_wdata_i[7:2],
        (demod ? shared_ctrl_q[1:0] : reg_wdata_i[1:0])};

    // edge qualification; code 11 is reserved and detects nothing
    assign cond_rise = (edge_sel == EDGE_RISE) || (edge_sel == EDGE_BOTH);
    assign cond_fall = (edge_sel == EDGE_FALL) || (edge_sel == EDGE_BOTH);

    ir_input_conditioner u_input
    (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .pin_i(demod_in_q),
        .filter_i(sub),
        .rise_o(rise_hit),
        .fall_o(fall_hit)
    );

    assign rise_flag_d = (demod && cond_rise && rise_hit) || (rise_flag_q &&
        !(wr_shared && demod && reg_wdata_i[SC_NARROW_LVL]));
    assign fall_flag_d = (demod && cond_fall && fall_hit) || (fall_flag_q &&
        !(wr_shared && demod && reg_wdata_i[SC_WIDE_LVL]));

    // counter output levels: idle at the opposite of the start level unless wide is forced
    assign narrow_lvl_d = !narrow_en_d ? !shared_ctrl_q[SC_NARROW_LVL] :
        narrow_start ? shared_ctrl_q[SC_NARROW_LVL] :
        (narrow_lvl_q ^ narrow_toggle_i);
    assign wide_lvl_d = (sub == SUB_FORCE0) ? 1'b0 :
        (sub == SUB_FORCE1) ? 1'b1 :
        !wide_en_d ? !shared_ctrl_q[SC_WIDE_LVL] :
        wide_start ? shared_ctrl_q[SC_WIDE_LVL] :
        (wide_lvl_q ^ wide_toggle_i);

    assign combined_d = (edge_sel == LOGIC_AND) ? (narrow_lvl_q & wide_lvl_q) :
        (edge_sel == LOGIC_OR) ? (narrow_lvl_q | wide_lvl_q) :
        (edge_sel == LOGIC_NOR) ? !(narrow_lvl_q | wide_lvl_q) :
        !(narrow_lvl_q & wide_lvl_q);

    assign shared_rd = demod ?
        {shared_ctrl_q[7:2], rise_flag_q, fall_flag_q} : shared_ctrl_q;

    assign rdata_d = !reg_rd_i ? 8'h00 :
        (reg_addr_i == NARROW_CTRL_OFS) ? narrow_ctrl_q :
        (reg_addr_i == SHARED_CTRL_OFS) ? shared_rd :
        (reg_addr_i == WIDE_CTRL_OFS) ? wide_ctrl_q : 8'h00;

    ir_prescaler u_narrow_pre
    (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .run_i(narrow_en),
        .sel_i(narrow_ctrl_q[NC_CLK_HI:NC_CLK_LO]),
        .tick_o(narrow_tick_o)
    );

    ir_prescaler u_wide_pre
    (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .run_i(wide_en),
        .sel_i(wide_ctrl_q[WC_CLK_HI:WC_CLK_LO]),
        .tick_o(wide_tick_o)
    );

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            narrow_ctrl_q <= NARROW_CTRL_RST;
            shared_ctrl_q <= SHARED_CTRL_RST;
            wide_ctrl_q <= WIDE_CTRL_RST;
            rise_flag_q <= 1'b0;
            fall_flag_q <= 1'b0;
        end
        else
        begin
            if (wr_narrow)
            begin
                narrow_ctrl_q <= narrow_ctrl_d;
            end
            else
            begin
                narrow_ctrl_q[NC_ENABLE] <= narrow_en_d;
                narrow_ctrl_q[NC_TIMEOUT] <= narrow_to_d;
            end
            if (wr_shared)
            begin
                shared_ctrl_q <= shared_ctrl_d;
            end
            if (wr_wide)
            begin
                wide_ctrl_q <= wide_ctrl_d;
            end
            else
            begin
                wide_ctrl_q[WC_ENABLE] <= wide_en_d;
                wide_ctrl_q[WC_TIMEOUT] <= wide_to_d;
            end
            rise_flag_q <= rise_flag_d;
            fall_flag_q <= fall_flag_d;
        end
    end

    // both pins pass two flops before the source mux, so switching the
    // source never looks at a raw asynchronous level; idle level is high
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            first_sync_q <= 2'h3;
            second_sync_q <= 2'h3;
            demod_in_q <= 1'b1;
        end
        else
        begin
            first_sync_q <= {first_sync_q[0], first_input_pin_i};
            second_sync_q <= {second_sync_q[0], second_input_pin_i};
            demod_in_q <= shared_ctrl_q[SC_ROUTE] ?
                second_sync_q[1] : first_sync_q[1];
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            narrow_lvl_q <= 1'b1;
            wide_lvl_q <= 1'b1;
            combined_q <= 1'b0;
        end
        else
        begin
            narrow_lvl_q <= narrow_lvl_d;
            wide_lvl_q <= wide_lvl_d;
            combined_q <= combined_d;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            reg_rdata_o <= 8'h00;
            narrow_run_o <= 1'b0;
            wide_run_o <= 1'b0;
            demod_mode_o <= 1'b0;
            narrow_single_o <= 1'b0;
            wide_single_o <= 1'b0;
            alternating_submode_o <= 1'b0;
            edge_rise_o <= 1'b0;
            edge_fall_o <= 1'b0;
            narrow_irq_o <= 1'b0;
            wide_irq_o <= 1'b0;
            narrow_out_pin_o <= 1'b0;
            wide_out_pin_o <= 1'b0;
            combined_out_pin_o <= 1'b0;
            narrow_counter_output_o <= 1'b1;
            wide_counter_output_o <= 1'b1;
        end
        else
        begin
            reg_rdata_o <= rdata_d;
            narrow_run_o <= narrow_en;
            wide_run_o <= wide_en;
            demod_mode_o <= demod;
            narrow_single_o <= narrow_ctrl_q[NC_SINGLE];
            wide_single_o <= wide_ctrl_q[WC_SINGLE];
            // selecting normal ends alternating operation at once
            alternating_submode_o <= !demod && (sub == SUB_ALTERNATE);
            edge_rise_o <= demod && cond_rise && rise_hit;
            edge_fall_o <= demod && cond_fall && fall_hit;
            narrow_irq_o <= (narrow_tc_i && narrow_ctrl_q[NC_CNT_MASK]) ||
                (demod && narrow_capture_i &&
                narrow_ctrl_q[NC_CAP_MASK]);
            wide_irq_o <= (wide_tc_i && wide_ctrl_q[WC_CNT_MASK]) ||
                (demod && wide_capture_i && wide_ctrl_q[WC_CAP_MASK]);
            narrow_out_pin_o <= narrow_ctrl_q[NC_PIN_SEL] ?
                narrow_lvl_q : port_data_i[0];
            wide_out_pin_o <= wide_ctrl_q[WC_PIN_SEL] ?
                wide_lvl_q : port_data_i[1];
            combined_out_pin_o <= (!demod && shared_ctrl_q[SC_ROUTE]) ?
                combined_q : port_data_i[2];
            narrow_counter_output_o <= narrow_lvl_q;
            wide_counter_output_o <= wide_lvl_q;
        end
    end
endmodule // ir_timer_control_regs

// *** rtl/ir_timer_pkg.sv ***
package ir_timer_pkg;

    localparam int REG_ADDR_W = 8;

    // register offsets
    localparam logic [7:0] NARROW_CTRL_OFS = 8'h00;
    localparam logic [7:0] SHARED_CTRL_OFS = 8'h01;
    localparam logic [7:0] WIDE_CTRL_OFS = 8'h02;

    // narrow_timer_control fields
    localparam int NC_ENABLE = 7;
    localparam int NC_SINGLE = 6;
    localparam int NC_TIMEOUT = 5;
    localparam int NC_CLK_HI = 4;
    localparam int NC_CLK_LO = 3;
    localparam int NC_CAP_MASK = 2;
    localparam int NC_CNT_MASK = 1;
    localparam int NC_PIN_SEL = 0;

    // shared_timer_control fields
    localparam int SC_MODE = 7;
    localparam int SC_ROUTE = 6;
    localparam int SC_LOGIC_HI = 5;
    localparam int SC_LOGIC_LO = 4;
    localparam int SC_SUB_HI = 3;
    localparam int SC_SUB_LO = 2;
    localparam int SC_NARROW_LVL = 1;
    localparam int SC_WIDE_LVL = 0;

    // wide_timer_control fields
    localparam int WC_ENABLE = 7;
    localparam int WC_SINGLE = 6;
    localparam int WC_TIMEOUT = 5;
    localparam int WC_CLK_HI = 4;
    localparam int WC_CLK_LO = 3;
    localparam int WC_CAP_MASK = 2;
    localparam int WC_CNT_MASK = 1;
    localparam int WC_PIN_SEL = 0;

    // power-on values
    localparam logic [7:0] NARROW_CTRL_RST = 8'h00;
    localparam logic [7:0] SHARED_CTRL_RST = 8'h00;
    localparam logic [7:0] WIDE_CTRL_RST = 8'h00;

    // combining logic codes (transmit)
    localparam logic [1:0] LOGIC_AND = 2'h0;
    localparam logic [1:0] LOGIC_OR = 2'h1;
    localparam logic [1:0] LOGIC_NOR = 2'h2;
    localparam logic [1:0] LOGIC_NAND = 2'h3;

    // edge select codes (demodulation)
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;

    // transmit submode codes
    localparam logic [1:0] SUB_NORMAL = 2'h0;
    localparam logic [1:0] SUB_ALTERNATE = 2'h1;
    localparam logic [1:0] SUB_FORCE0 = 2'h2;
    localparam logic [1:0] SUB_FORCE1 = 2'h3;

    // glitch filter codes and widths in system clocks
    localparam logic [1:0] FILT_NONE = 2'h0;
    localparam logic [1:0] FILT_SHORT = 2'h1;
    localparam logic [1:0] FILT_LONG = 2'h2;
    localparam int FILT_SHORT_CLKS = 4;
    localparam int FILT_LONG_CLKS = 8;

    localparam int PRESCALE_W = 3;

endpackage

// *** test/ir_pin_model.sv ***
`timescale 1ns/1ps
// receiver lines idle high; a mark pulls only the chosen line low, so an
// edge seen from the other line points at a routing fault
module ir_pin_model (
    input wire logic clk_sys_i,
    input wire logic go_i,
    input wire logic sel_i,
    input wire logic [3:0] width_i,
    output logic first_pin_o,
    output logic second_pin_o
);
    logic [3:0] left_q = 4'h0;
    always_ff @(posedge clk_sys_i)
    begin
        if (go_i)
            left_q <= width_i;
        else if (left_q != 4'h0)
            left_q <= left_q - 4'h1;
    end
    assign first_pin_o = !(left_q != 4'h0 && !sel_i);
    assign second_pin_o = !(left_q != 4'h0 && sel_i);
endmodule // ir_pin_model

// *** test/ir_timer_control_regs_checker.sv ***
`timescale 1ns/1ps
module ir_timer_control_regs_checker
    import ir_timer_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [REG_ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic narrow_tc_i,
    input wire logic wide_tc_i,
    input wire logic narrow_capture_i,
    input wire logic wide_capture_i,
    input wire logic narrow_irq_o,
    input wire logic wide_irq_o,
    input wire logic edge_rise_o,
    input wire logic edge_fall_o,
    input wire logic wide_run_o,
    input wire logic demod_mode_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    chk_narrow_irq_cause: assert property (
        narrow_irq_o |-> $past(narrow_tc_i) || $past(narrow_capture_i))
        else $error("narrow interrupt without a cause");
    chk_wide_irq_cause: assert property (
        wide_irq_o |-> $past(wide_tc_i) || $past(wide_capture_i))
        else $error("wide interrupt without a cause");
    chk_edge_kind_excl: assert property (
        !(edge_rise_o && edge_fall_o))
        else $error("rise and fall reported together");
    chk_edge_in_demod: assert property (
        edge_rise_o || edge_fall_o |-> demod_mode_o)
        else $error("edge reported in transmit mode");
    chk_rdata_idle: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data without a read");
    chk_unmapped_read: assert property (
        $past(reg_rd_i) && $past(reg_addr_i) > WIDE_CTRL_OFS
        |-> reg_rdata_o == 8'h00)
        else $error("unmapped read returned data");
    chk_wide_run_start: assert property (
        reg_wr_i && reg_addr_i == WIDE_CTRL_OFS && reg_wdata_i[WC_ENABLE]
        |-> ##2 wide_run_o)
        else $error("wide counter did not start");
    chk_wide_run_stop: assert property (
        reg_wr_i && reg_addr_i == WIDE_CTRL_OFS && !reg_wdata_i[WC_ENABLE]
        |-> ##2 !wide_run_o)
        else $error("wide counter did not stop");
    chk_mode_follow: assert property (
        reg_wr_i && reg_addr_i == SHARED_CTRL_OFS
        |-> ##2 demod_mode_o == $past(reg_wdata_i[SC_MODE], 2))
        else $error("mode output differs from written mode");
endmodule // ir_timer_control_regs_checker

bind ir_timer_control_regs ir_timer_control_regs_checker u_chk (
    .clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .narrow_tc_i, .wide_tc_i, .narrow_capture_i,
    .wide_capture_i, .narrow_irq_o, .wide_irq_o, .edge_rise_o,
    .edge_fall_o, .wide_run_o, .demod_mode_o
);

// *** test/tb_ir_timer_control_regs.sv ***
`timescale 1ns/1ps
module tb_ir_timer_control_regs
    import ir_timer_pkg::*;
;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    // narrow tc, wide tc, narrow capture, wide capture, toggles
    logic [5:0] ev = 6'h00;
    logic [2:0] port_data_i = 3'h0;
    logic go = 1'b0;
    logic sel = 1'b0;
    logic [3:0] wid = 4'h0;
    logic pin_a, pin_b, n_run, w_run, n_tick, w_tick, demod, alt;
    logic rise, fall, n_irq, w_irq, n_pin, w_pin, c_pin, n_out, w_out;
    logic n_sgl, w_sgl;
    int err_count = 0;
    int check_count = 0;
    int cyc = 0;
    int ref_q [3] = '{0, 0, 0};
    logic [31:0] seed = 32'hBB56;

    always #5 clk_sys_i = ~clk_sys_i;

    ir_pin_model u_pins (.clk_sys_i(clk_sys_i), .go_i(go), .sel_i(sel),
        .width_i(wid), .first_pin_o(pin_a), .second_pin_o(pin_b));

    ir_timer_control_regs u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .narrow_tc_i(ev[0]), .wide_tc_i(ev[1]), .narrow_capture_i(ev[2]),
        .wide_capture_i(ev[3]), .narrow_toggle_i(ev[4]),
        .wide_toggle_i(ev[5]), .narrow_run_o(n_run), .wide_run_o(w_run),
        .narrow_tick_o(n_tick), .wide_tick_o(w_tick), .demod_mode_o(demod),
        .narrow_single_o(n_sgl), .wide_single_o(w_sgl),
        .alternating_submode_o(alt),
        .edge_rise_o(rise), .edge_fall_o(fall), .narrow_irq_o(n_irq),
        .wide_irq_o(w_irq), .first_input_pin_i(pin_a),
        .second_input_pin_i(pin_b), .port_data_i(port_data_i),
        .narrow_out_pin_o(n_pin), .wide_out_pin_o(w_pin),
        .combined_out_pin_o(c_pin), .narrow_counter_output_o(n_out),
        .wide_counter_output_o(w_out));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
            err_count++;
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // flags are write-one-to-clear, so the model keeps them across writes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        if (a == 8'h01)
            ref_q[1] = ref_q[1][7] ? (d & 8'hFC) | (ref_q[1] & ~d & 8'h03) : d;
        else if (a == 8'h00 || a == 8'h02)
            ref_q[a] = (d & 8'hDF) | (ref_q[a] & ~d & 8'h20);
    endtask

    task automatic rc(input logic [7:0] a);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 check(reg_rdata_o, a < 3 ? ref_q[a][7:0] : 8'h00);
    endtask

    task automatic pulse(input int k, input logic exp);
        @(posedge clk_sys_i);
        ev[k] <= 1'b1;
        @(posedge clk_sys_i);
        ev[k] <= 1'b0;
        #1 check(k % 2 ? w_irq : n_irq, exp);
        if (k < 2)
            ref_q[k * 2] |= 8'h20;
    endtask

    task automatic pin_pulse(input logic s, input logic [3:0] w,
        input logic er, input logic ef);
        int r = 0;
        int f = 0;
        @(posedge clk_sys_i);
        go <= 1'b1;
        sel <= s;
        wid <= w;
        @(posedge clk_sys_i);
        go <= 1'b0;
        repeat (40)
        begin
            @(posedge clk_sys_i);
            #1 r += rise;
            f += fall;
        end
        check(r[7:0], er);
        check(f[7:0], ef);
        ref_q[1] |= {er, ef};
    endtask

    always @(posedge clk_sys_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            finish_test();
        end
    end

    initial
    begin
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        wr(8'h07, 8'hFF);
        for (int a = 0; a < 4; a++)
            rc(a);
        $display("test reset values done");
        for (int c = 0; c < 2; c++)
            for (int s = 0; s < 4; s++)
            begin
                int n;
                n = 0;
                wr(c * 2, 8'h20);
                wr(c * 2, 8'h81 | (s << 3) | ((s % 2) << 6));
                repeat (8) @(posedge clk_sys_i);
                #1 check(c ? w_out : n_out, 1'b0);
                check(c ? w_pin : n_pin, 1'b0);
                check(c ? w_sgl : n_sgl, s % 2);
                check(c ? w_run : n_run, 1'b1);
                rc(c * 2);
                repeat (64)
                begin
                    @(posedge clk_sys_i);
                    #1 n += c ? w_tick : n_tick;
                end
                check(n[7:0], 8'h40 >> s);
                pulse(4 + c, 1'b0);
                @(posedge clk_sys_i);
                #1 check(c ? w_out : n_out, 1'b1);
                check(c ? w_pin : n_pin, 1'b1);
                pulse(c, 1'b0);
                @(posedge clk_sys_i);
                #1 check(c ? w_run : n_run, s % 2 == 0);
                wr(c * 2, 8'h00);
            end
        $display("test run and prescale done");
        for (int i = 0; i < 16; i++)
        begin
            logic [7:0] v;
            logic n;
            logic w;
            logic c;
            seed = xs(seed);
            v = {1'b0, seed[6], i[1:0], i[3:2], seed[1:0]};
            port_data_i <= seed[10:8];
            wr(8'h01, v);
            repeat (3) @(posedge clk_sys_i);
            #1 n = !v[1];
            w = v[3] ? v[2] : !v[0];
            c = v[5] ? !(v[4] ? n & w : n | w) : (v[4] ? n | w : n & w);
            check(n_out, n);
            check(w_out, w);
            check(c_pin, v[6] ? c : port_data_i[2]);
            check({w_pin, n_pin}, port_data_i[1:0]);
            check(alt, v[3:2] == 2'h1);
            rc(8'h01);
        end
        $display("test transmit outputs done");
        for (int k = 0; k < 2; k++)
        begin
            wr(k * 2, 8'h02);
            pulse(k, 1'b1);
            rc(k * 2);
            wr(k * 2, 8'h02);
            rc(k * 2);
            wr(k * 2, 8'h20);
            rc(k * 2);
            pulse(k, 1'b0);
            wr(k * 2, 8'h20);
        end
        $display("test timeout flags done");
        wr(8'h01, 8'hA0);
        pin_pulse(1'b0, 4'h6, 1'b1, 1'b1);
        rc(8'h01);
        wr(8'h01, 8'hA1);
        rc(8'h01);
        for (int e = 0; e < 4; e++)
        begin
            wr(8'h01, 8'h83 | (e << 4));
            pin_pulse(1'b0, 4'h6, e == 1 || e == 2, e == 0 || e == 2);
            rc(8'h01);
        end
        wr(8'h01, 8'hEB);
        pin_pulse(1'b1, 4'h7, 1'b0, 1'b0);
        pin_pulse(1'b1, 4'h9, 1'b1, 1'b1);
        pin_pulse(1'b0, 4'h9, 1'b0, 1'b0);
        wr(8'h01, 8'hE7);
        pin_pulse(1'b1, 4'h3, 1'b0, 1'b0);
        pin_pulse(1'b1, 4'h5, 1'b1, 1'b1);
        rc(8'h01);
        for (int k = 2; k < 4; k++)
        begin
            wr(k * 2 - 4, 8'h04);
            pulse(k, 1'b1);
            wr(k * 2 - 4, 8'h00);
            pulse(k, 1'b0);
        end
        wr(8'h01, 8'h00);
        $display("test demodulation done");
        finish_test();
    end
endmodule // tb_ir_timer_control_regs
